//--- verilog/ococs_consts.vh
// Constants for the output control command set block.
// Assumes inclusion by ococs_core.v only.
`ifndef OCOCS_CONSTS_VH
`define OCOCS_CONSTS_VH
// Command codes
`define OCOCS_C_OP      8'h01
`define OCOCS_C_CFG     8'h02
`define OCOCS_C_CLR     8'h03
`define OCOCS_C_STORE   8'h11
`define OCOCS_C_TRIM    8'h22
`define OCOCS_C_MHI     8'h25
`define OCOCS_C_MLO     8'h26
`define OCOCS_C_SCALE   8'h29
`define OCOCS_C_OCW     8'h4A
`define OCOCS_C_RISE    8'h61
`define OCOCS_C_SUM     8'h78
`define OCOCS_C_TEMP    8'h7D
`define OCOCS_C_CML     8'h7E
// Enable config bits, operation on bit and config reset value
`define OCOCS_PU        4
`define OCOCS_CMD       3
`define OCOCS_CPR       2
`define OCOCS_POL       1
`define OCOCS_ON        7
`define OCOCS_CFG_RST   5'h17
// Fixed exponents in bits 15:11, ratio and limit mantissas
`define OCOCS_EXP_RISE  5'h1C
`define OCOCS_EXP_SCALE 5'h17
`define OCOCS_EXP_OCW   5'h1F
`define OCOCS_SCALE_RST 10'h100
`define OCOCS_SCALE_MAX 11'h200
`define OCOCS_OC_25A    6'h32
// Nominal reference 600 mV in 2^-19 V units, trim window 25 percent of it
`define OCOCS_REF_NOM   28'h004CCCD
`define OCOCS_TRIM_LIM  28'h0013333
// Status bit positions
`define OCOCS_S_OFF     6
`define OCOCS_S_TEMP    2
`define OCOCS_S_CML     1
`define OCOCS_CML_CMD   7
`define OCOCS_CML_DATA  6
`define OCOCS_CML_PEC   5
`define OCOCS_T_FAULT   7
`define OCOCS_T_WARN    6
// Checking byte polynomial
`define OCOCS_CRC_POLY  8'h07
// Bus engine states
`define OCOCS_ST_IDLE   3'h0
`define OCOCS_ST_RX     3'h1
`define OCOCS_ST_RACK   3'h2
`define OCOCS_ST_TX     3'h3
`define OCOCS_ST_TACK   3'h4
`define OCOCS_ST_IGN    3'h5
`endif

//--- verilog/ococs_core.v
// Management bus slave and output control command decoder.
// Assumes pins arrive unsynchronised; converter inputs are levels.
`include "ococs_consts.vh"

// Notes on behaviour
// - operation bit 7 enables the output
// - config bits 4..1 writable, bit 0 fixed
// - policy 0 starts whenever power is present
// - command gate selects operation enable bit
// - pin gate requires on/off pin asserted
// - rise word exponent -4, mantissa top zero
// - eight rise codes, 625us to 9ms
// - trim and margin move the 600mV reference
// - ratio exponent -9, default 256, max 512
// - derived levels follow the programmed ratio
// - offset exponent -10 added to nominal
// - offset top two bits must agree
// - trim range plus minus 25 percent
// - bad offset reverts nominal, raises faults
// - margins exponent -10, top bit zero, storable
// - operation bits 5..2 select margin mode
// - overcurrent limit exponent -1, six bits
// - overcurrent limit may be fixed at 25A
// - thermal status reports fault and warning
// - rise, ratio and limit words are 5-bit exponent, 11-bit mantissa
// - every transaction carries a checking byte
module ococs_core #(
   parameter [6:0] DEV_ADDR = 7'h40,
   parameter       OC_FIXED = 1,
   parameter [5:0] OC_CAL   = 6'h32
) (
   // System
   input  wire        clk_i,
   input  wire        rst_b_i,
   // Management bus pins
   input  wire        scl_i,
   input  wire        sda_i,
   output wire        sda_o,
   output wire        sda_oe_b_o,
   output wire        alert_o,
   output wire        alert_oe_b_o,
   // Converter side
   input  wire        on_pin_i,
   input  wire        power_ok_i,
   input  wire        ot_fault_i,
   input  wire        ot_warn_i,
   output reg         out_en_o,
   output reg  [1:0]  margin_o,
   output reg         margin_act_o,
   output reg  [2:0]  rise_sel_o,
   output reg  [27:0] ref_code_o,
   output reg         store_o
);

   function [7:0] crc8;
      input [7:0] c;
      input [7:0] d;
      integer     i;
      reg   [7:0] x;
      begin
         x = c ^ d;
         for (i = 0; i < 8; i = i + 1)
            x = x[7] ? ((x << 1) ^ `OCOCS_CRC_POLY) : (x << 1);
         crc8 = x;
      end
   endfunction

   reg  [4:0]  s1_r, s2_r, s3_r, f_r;
   reg         pscl_r, psda_r;
   reg  [2:0]  st_r;
   reg  [3:0]  bit_r;
   reg  [7:0]  sh_r, cmd_r, d0_r, d1_r, crc_r, txb_r;
   reg  [2:0]  nb_r;
   reg  [1:0]  tix_r;
   reg         rd_r, first_r, busy_r, drv_r, nack_r;
   reg  [7:0]  op_r;
   reg  [4:0]  cfg_r;
   reg  [9:0]  scale_r;
   reg  [15:0] trim_r;
   reg  [14:0] mhi_r, mlo_r;
   reg  [5:0]  ocw_r;
   reg  [7:0]  cml_r, temp_r;
   reg  [7:0]  cml_set, sum_st;
   reg  [15:0] rdata;
   reg  [1:0]  len;
   reg         known;
   reg  [2:0]  rise_code;
   reg         rise_ok;

   wire        scl_f   = f_r[0];
   wire        sda_f   = f_r[1];
   wire        pin_f   = f_r[2];
   wire        scl_r   = scl_f & ~pscl_r;
   wire        scl_fl  = ~scl_f & pscl_r;
   wire        start   = scl_f & pscl_r & psda_r & ~sda_f;
   wire        stop    = scl_f & pscl_r & ~psda_r & sda_f;
   wire [15:0] w       = {d1_r, d0_r};
   wire        commit  = stop & busy_r & ~rd_r & (st_r != `OCOCS_ST_IGN)
                         & (nb_r != 3'h0);
   wire        frame_ok = (nb_r == {1'b0, len} + 3'h2) & (crc_r == 8'h00);
   wire        do_wr   = commit & known & frame_ok;
   wire        clr     = do_wr & (cmd_r == `OCOCS_C_CLR);
   wire signed [26:0] trim_p = $signed(w) * $signed({1'b0, scale_r});
   wire [26:0] trim_abs = trim_p[26] ? -trim_p : trim_p;
   wire        trim_ok = (w[15] == w[14])
                         & ({1'b0, trim_abs} <= `OCOCS_TRIM_LIM);
   wire signed [16:0] mg_sum = $signed({2'b00,
                         (margin_o[1] ? mhi_r : mlo_r)})
                         + $signed({trim_r[15], trim_r});
   wire signed [27:0] mg_ref = mg_sum * $signed({1'b0, scale_r});
   wire signed [27:0] tr_ref = $signed(`OCOCS_REF_NOM)
                         + $signed({trim_r[15], trim_r})
                         * $signed({1'b0, scale_r});
   wire        pin_on  = cfg_r[`OCOCS_POL] ? pin_f : ~pin_f;

   assign sda_o        = 1'b0;
   assign sda_oe_b_o   = ~drv_r;
   assign alert_o      = 1'b0;
   assign alert_oe_b_o = ~((|cml_r) | (|temp_r));

   // Rise code lookup, exponent and high mantissa bits checked
   always @* begin
      rise_ok   = (w[15:11] == `OCOCS_EXP_RISE) & (w[10:9] == 2'b00);
      rise_code = 3'h0;
      case (w[8:0])
         9'h00A: rise_code = 3'h0;
         9'h00E: rise_code = 3'h1;
         9'h013: rise_code = 3'h2;
         9'h01D: rise_code = 3'h3;
         9'h02B: rise_code = 3'h4;
         9'h043: rise_code = 3'h5;
         9'h060: rise_code = 3'h6;
         9'h090: rise_code = 3'h7;
         default: rise_ok = 1'b0;
      endcase
   end

   // Command table: length, read data
   always @* begin
      sum_st = 8'h00;
      sum_st[`OCOCS_S_OFF]  = ~out_en_o;
      sum_st[`OCOCS_S_TEMP] = |temp_r;
      sum_st[`OCOCS_S_CML]  = |cml_r;
      known = 1'b1;
      len   = 2'h2;
      rdata = 16'hFFFF;
      case (cmd_r)
         `OCOCS_C_OP:    begin len = 2'h1; rdata = {8'h00, op_r}; end
         `OCOCS_C_CFG:   begin len = 2'h1; rdata = {11'h000, cfg_r}; end
         `OCOCS_C_CLR:   len = 2'h0;
         `OCOCS_C_STORE: len = 2'h0;
         `OCOCS_C_SCALE: rdata = {`OCOCS_EXP_SCALE, 1'b0, scale_r};
         `OCOCS_C_TRIM:  rdata = trim_r;
         `OCOCS_C_MHI:   rdata = {1'b0, mhi_r};
         `OCOCS_C_MLO:   rdata = {1'b0, mlo_r};
         `OCOCS_C_OCW:   rdata = {`OCOCS_EXP_OCW, 5'h00, ocw_r};
         `OCOCS_C_SUM:   begin len = 2'h1; rdata = {8'h00, sum_st}; end
         `OCOCS_C_CML:   begin len = 2'h1; rdata = {8'h00, cml_r}; end
         `OCOCS_C_TEMP:  begin len = 2'h1; rdata = {8'h00, temp_r}; end
         `OCOCS_C_RISE: begin
            case (rise_sel_o)
               3'h0: rdata = {`OCOCS_EXP_RISE, 11'h00A};
               3'h1: rdata = {`OCOCS_EXP_RISE, 11'h00E};
               3'h2: rdata = {`OCOCS_EXP_RISE, 11'h013};
               3'h3: rdata = {`OCOCS_EXP_RISE, 11'h01D};
               3'h4: rdata = {`OCOCS_EXP_RISE, 11'h02B};
               3'h5: rdata = {`OCOCS_EXP_RISE, 11'h043};
               3'h6: rdata = {`OCOCS_EXP_RISE, 11'h060};
               default: rdata = {`OCOCS_EXP_RISE, 11'h090};
            endcase
         end
         default: known = 1'b0;
      endcase
   end

   // Fault events from the command side
   always @* begin
      cml_set = 8'h00;
      cml_set[`OCOCS_CML_CMD] = commit & ~known;
      cml_set[`OCOCS_CML_PEC] = commit & known & ~frame_ok;
      if (do_wr) begin
         case (cmd_r)
            `OCOCS_C_TRIM:  cml_set[`OCOCS_CML_DATA] = ~trim_ok;
            `OCOCS_C_RISE:  cml_set[`OCOCS_CML_DATA] = ~rise_ok;
            `OCOCS_C_SCALE: cml_set[`OCOCS_CML_DATA] =
               (w[15:11] != `OCOCS_EXP_SCALE) | (w[10:0] > `OCOCS_SCALE_MAX);
            `OCOCS_C_MHI:   cml_set[`OCOCS_CML_DATA] = w[15];
            `OCOCS_C_MLO:   cml_set[`OCOCS_CML_DATA] = w[15];
            `OCOCS_C_OCW:   cml_set[`OCOCS_CML_DATA] =
               (w[15:11] != `OCOCS_EXP_OCW) | (w[10:6] != 5'h00);
            default:        cml_set[`OCOCS_CML_DATA] = 1'b0;
         endcase
      end
   end

   // Pin synchronisers: act once second and third stage agree
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_r   <= 5'h03;
         s2_r   <= 5'h03;
         s3_r   <= 5'h03;
         f_r    <= 5'h03;
         pscl_r <= 1'b1;
         psda_r <= 1'b1;
      end else begin
         s1_r   <= {ot_warn_i, ot_fault_i, on_pin_i, sda_i, scl_i};
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         f_r    <= (s2_r & s3_r) | (f_r & (s2_r | s3_r));
         pscl_r <= scl_f;
         psda_r <= sda_f;
      end
   end

   // Bus engine
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= `OCOCS_ST_IDLE;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         cmd_r <= 8'h00;
         d0_r <= 8'h00;
         d1_r <= 8'h00;
         crc_r <= 8'h00;
         txb_r <= 8'h00;
         nb_r <= 3'h0;
         tix_r <= 2'h0;
         rd_r <= 1'b0;
         first_r <= 1'b0;
         busy_r <= 1'b0;
         drv_r <= 1'b0;
         nack_r <= 1'b0;
      end else if (start) begin
         st_r    <= `OCOCS_ST_RX;
         bit_r   <= 4'h0;
         first_r <= 1'b1;
         busy_r  <= 1'b1;
         drv_r   <= 1'b0;
         if (!busy_r) begin
            crc_r <= 8'h00;
            nb_r  <= 3'h0;
            rd_r  <= 1'b0;
         end
      end else if (stop) begin
         st_r   <= `OCOCS_ST_IDLE;
         busy_r <= 1'b0;
         drv_r  <= 1'b0;
      end else begin
         case (st_r)
            `OCOCS_ST_RX: begin
               if (scl_r && bit_r != 4'h8) begin
                  sh_r  <= {sh_r[6:0], sda_f};
                  bit_r <= bit_r + 4'h1;
               end else if (scl_fl && bit_r == 4'h8) begin
                  if (first_r && sh_r[7:1] != DEV_ADDR)
                     st_r <= `OCOCS_ST_IGN;
                  else begin
                     crc_r <= crc8(crc_r, sh_r);
                     drv_r <= 1'b1;
                     st_r  <= `OCOCS_ST_RACK;
                     if (first_r) begin
                        rd_r  <= sh_r[0];
                        tix_r <= 2'h0;
                     end else begin
                        if (nb_r == 3'h0) cmd_r <= sh_r;
                        if (nb_r == 3'h1) d0_r <= sh_r;
                        if (nb_r == 3'h2) d1_r <= sh_r;
                        if (nb_r != 3'h7) nb_r <= nb_r + 3'h1;
                     end
                  end
                  first_r <= 1'b0;
               end
            end
            `OCOCS_ST_RACK: if (scl_fl) begin
               bit_r <= 4'h0;
               if (rd_r) begin
                  txb_r <= rdata[7:0];
                  sh_r  <= rdata[7:0];
                  drv_r <= ~rdata[7];
                  st_r  <= `OCOCS_ST_TX;
               end else begin
                  drv_r <= 1'b0;
                  st_r  <= `OCOCS_ST_RX;
               end
            end
            `OCOCS_ST_TX: if (scl_fl) begin
               if (bit_r == 4'h7) begin
                  drv_r <= 1'b0;
                  crc_r <= crc8(crc_r, txb_r);
                  st_r  <= `OCOCS_ST_TACK;
               end else begin
                  sh_r  <= {sh_r[6:0], 1'b0};
                  drv_r <= ~sh_r[6];
                  bit_r <= bit_r + 4'h1;
               end
            end
            `OCOCS_ST_TACK: begin
               if (scl_r)
                  nack_r <= sda_f;
               if (scl_fl) begin
                  if (nack_r)
                     st_r <= `OCOCS_ST_IGN;
                  else begin
                     tix_r <= tix_r + 2'h1;
                     bit_r <= 4'h0;
                     st_r  <= `OCOCS_ST_TX;
                     if (tix_r == 2'h0 && len == 2'h2) begin
                        txb_r <= rdata[15:8];
                        sh_r  <= rdata[15:8];
                        drv_r <= ~rdata[15];
                     end else if (tix_r == 2'h0 ||
                                  (tix_r == 2'h1 && len == 2'h2)) begin
                        txb_r <= crc_r;
                        sh_r  <= crc_r;
                        drv_r <= ~crc_r[7];
                     end else begin
                        txb_r <= 8'hFF;
                        sh_r  <= 8'hFF;
                        drv_r <= 1'b0;
                     end
                  end
               end
            end
            default: drv_r <= 1'b0;
         endcase
      end
   end

   // Command registers, flags and converter outputs
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         op_r <= 8'h00;
         cfg_r <= `OCOCS_CFG_RST;
         scale_r <= `OCOCS_SCALE_RST;
         trim_r <= 16'h0000;
         mhi_r <= 15'h0000;
         mlo_r <= 15'h0000;
         ocw_r <= `OCOCS_OC_25A;
         cml_r <= 8'h00;
         temp_r <= 8'h00;
         out_en_o <= 1'b0;
         margin_o <= 2'h0;
         margin_act_o <= 1'b0;
         rise_sel_o <= 3'h0;
         ref_code_o <= 28'h0000000;
         store_o <= 1'b0;
      end else begin
         if (OC_FIXED == 0 && ocw_r == `OCOCS_OC_25A && !do_wr)
            ocw_r <= OC_CAL;
         if (do_wr) begin
            case (cmd_r)
               `OCOCS_C_OP:   op_r <= d0_r;
               `OCOCS_C_CFG:  cfg_r[4:1] <= d0_r[4:1];
               `OCOCS_C_RISE: if (rise_ok) rise_sel_o <= rise_code;
               `OCOCS_C_SCALE:
                  if (w[15:11] == `OCOCS_EXP_SCALE &&
                      w[10:0] <= `OCOCS_SCALE_MAX)
                     scale_r <= w[9:0];
               `OCOCS_C_TRIM: trim_r <= trim_ok ? w : 16'h0000;
               `OCOCS_C_MHI:  if (!w[15]) mhi_r <= w[14:0];
               `OCOCS_C_MLO:  if (!w[15]) mlo_r <= w[14:0];
               `OCOCS_C_OCW:
                  if (OC_FIXED == 0 && w[15:11] == `OCOCS_EXP_OCW &&
                      w[10:6] == 5'h00)
                     ocw_r <= w[5:0];
               default: ;
            endcase
         end
         if (OC_FIXED != 0)
            ocw_r <= `OCOCS_OC_25A;
         // Set beats clear
         cml_r  <= (clr ? 8'h00 : cml_r) | cml_set;
         temp_r <= (clr ? 8'h00 : temp_r)
                   | {f_r[3], f_r[4], 6'h00};
         store_o <= do_wr & (cmd_r == `OCOCS_C_STORE);
         out_en_o <= power_ok_i & (~cfg_r[`OCOCS_PU] |
                     ((~cfg_r[`OCOCS_CMD] | op_r[`OCOCS_ON]) &
                      (~cfg_r[`OCOCS_CPR] | pin_on)));
         case (op_r[5:2])
            4'b0101: begin margin_o <= 2'h1; margin_act_o <= 1'b0; end
            4'b0110: begin margin_o <= 2'h1; margin_act_o <= 1'b1; end
            4'b1001: begin margin_o <= 2'h2; margin_act_o <= 1'b0; end
            4'b1010: begin margin_o <= 2'h2; margin_act_o <= 1'b1; end
            default: begin margin_o <= 2'h0; margin_act_o <= 1'b0; end
         endcase
         ref_code_o <= (margin_o != 2'h0) ? mg_ref : tr_ref;
      end
   end

endmodule // ococs_core

//--- verif/ococs_props.sv
// Pin-level checks for the output control command block.
// Assumes one clock domain and an idle-high bus between frames.
module ococs_props (
   // System
   input wire        clk_i,
   input wire        rst_b_i,
   // Bus pins
   input wire        scl_i,
   input wire        sda_i,
   input wire        sda_o,
   input wire        sda_oe_b_o,
   input wire        alert_o,
   input wire        alert_oe_b_o,
   // Converter side
   input wire        power_ok_i,
   input wire        ot_fault_i,
   input wire        out_en_o,
   input wire [1:0]  margin_o,
   input wire [2:0]  rise_sel_o,
   input wire [27:0] ref_code_o,
   input wire        store_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   a_power_gate: assert property (!power_ok_i |=> !out_en_o)
      else $error("output on without input power");
   a_store_pulse: assert property (store_o |=> !store_o)
      else $error("store pulse longer than one cycle");
   a_store_idle: assert property (store_o |-> scl_i && sda_i)
      else $error("store pulse outside stop");
   a_margin_code: assert property (margin_o != 2'h3)
      else $error("illegal margin code");
   a_margin_commit: assert property (
      $changed(margin_o) |-> scl_i && sda_i)
      else $error("margin changed inside a frame");
   a_ref_window: assert property (ref_code_o == 28'h0000000 ||
      (ref_code_o >= 28'h003999A && ref_code_o <= 28'h0060000))
      else $error("reference outside trim window");
   a_ref_commit: assert property (
      $changed(ref_code_o) |-> scl_i && sda_i)
      else $error("reference changed inside a frame");
   a_rise_commit: assert property (
      $changed(rise_sel_o) |-> scl_i && sda_i)
      else $error("rise code changed inside a frame");
   a_sda_low_phase: assert property (
      $changed(sda_oe_b_o) |-> !scl_i)
      else $error("data pin moved while clock high");
   a_open_drain: assert property (!sda_o && !alert_o)
      else $error("open drain value not low");
   a_therm_alert: assert property (
      $rose(ot_fault_i) |-> ##[1:10] !alert_oe_b_o)
      else $error("no alert after thermal fault");
endmodule // ococs_props

bind ococs_core ococs_props u_props (
   .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o), .alert_o(alert_o),
   .alert_oe_b_o(alert_oe_b_o), .power_ok_i(power_ok_i),
   .ot_fault_i(ot_fault_i), .out_en_o(out_en_o), .margin_o(margin_o),
   .rise_sel_o(rise_sel_o), .ref_code_o(ref_code_o), .store_o(store_o)
);

//--- verif/ococs_host.sv
// Management bus host model with checking bytes, 160 ns bus clock.
// Assumes sda_i is the resolved wire with a pull-up.
module ococs_host #(
   parameter logic [6:0] DEV_ADDR = 7'h40
) (
   // Clock
   input  wire logic clk_i,
   // Bus
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_b_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int         lo_ext = 0;
   logic [7:0] crc;
   logic       nak;
   initial begin
      scl_o = 1'b1;
      sda_b_o = 1'b1;
   end
   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      for (int i = 0; i < 8; i++)
         x = {x[6:0], 1'b0} ^ (x[7] ? 8'h07 : 8'h00);
      return x;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      tick(2);
      sda_b_o = b;
      tick(6 + lo_ext);
      scl_o = 1'b1;
      tick(4);
      r = sda_i;
      tick(4);
      scl_o = 1'b0;
   endtask
   task automatic start();
      sda_b_o = 1'b1;
      tick(8);
      scl_o = 1'b1;
      tick(8);
      sda_b_o = 1'b0;
      tick(8);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sda_b_o = 1'b0;
      tick(6);
      scl_o = 1'b1;
      tick(8);
      sda_b_o = 1'b1;
      tick(8);
   endtask
   task automatic send(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      nak = nak | r;
      crc = crc8(crc, d);
   endtask
   task automatic recv(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, r);
      crc = crc8(crc, d);
   endtask
   task automatic write_cmd(input logic [7:0] c, input logic [15:0] v,
                            input int n, input logic bad);
      crc = 8'h00;
      nak = 1'b0;
      start();
      send({DEV_ADDR, 1'b0});
      send(c);
      if (n > 0)
         send(v[7:0]);
      if (n > 1)
         send(v[15:8]);
      send(crc ^ {7'h00, bad});
      stop();
   endtask
   task automatic read_cmd(input logic [7:0] c, input int n,
                           output logic [15:0] v, output logic ok);
      logic [7:0] b;
      logic [7:0] e;
      crc = 8'h00;
      nak = 1'b0;
      v = 16'h0000;
      start();
      send({DEV_ADDR, 1'b0});
      send(c);
      start();
      send({DEV_ADDR, 1'b1});
      recv(1'b0, b);
      v[7:0] = b;
      if (n > 1) begin
         recv(1'b0, b);
         v[15:8] = b;
      end
      e = crc;
      recv(1'b1, b);
      ok = (b === e) && !nak;
      stop();
   endtask
endmodule // ococs_host

//--- verif/ococs_core_test.sv
// Self-checking bench for the output control command block.
// Assumes the host model owns the bus; the data wire has a pull-up.
module ococs_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        on_pin_i = 1'b0;
   logic        power_ok_i = 1'b0;
   logic        ot_fault_i = 1'b0;
   logic        ot_warn_i = 1'b0;
   wire         scl, sda_b, sda_o, sda_oe_b, sda_w, alert_o, alert_oe_b;
   wire         out_en_o, margin_act_o, store_o;
   wire [1:0]   margin_o;
   wire [2:0]   rise_sel_o;
   wire [27:0]  ref_code_o;
   int          error_cnt = 0;
   int          checked = 0;
   int          store_cnt = 0;
   logic [15:0] v;
   logic        ok;
   assign sda_w = (sda_oe_b | sda_o) & sda_b;
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (store_o === 1'b1)
         store_cnt <= store_cnt + 1;
   ococs_core u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b),
      .alert_o(alert_o), .alert_oe_b_o(alert_oe_b), .on_pin_i(on_pin_i),
      .power_ok_i(power_ok_i), .ot_fault_i(ot_fault_i),
      .ot_warn_i(ot_warn_i), .out_en_o(out_en_o), .margin_o(margin_o),
      .margin_act_o(margin_act_o), .rise_sel_o(rise_sel_o),
      .ref_code_o(ref_code_o), .store_o(store_o));
   ococs_host u_host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_b_o(sda_b));
   task automatic chk(input string n, input logic [27:0] g,
                      input logic [27:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n);
      u_host.write_cmd(c, d, n, 1'b0);
      chk("ack", 28'(u_host.nak), 28'h0000000);
   endtask
   task automatic rd(input string s, input logic [7:0] c, input int n,
                     input logic [15:0] e);
      u_host.read_cmd(c, n, v, ok);
      chk(s, 28'(v), 28'(e));
      chk("read pec", 28'(ok), 28'h0000001);
   endtask
   // Pin sync plus one register stage
   task automatic settle_en(input logic e);
      repeat (8) @(negedge clk_i);
      chk("out_en", 28'(out_en_o), 28'(e));
   endtask
   task automatic t_reset();
      chk("ref nominal", ref_code_o, 28'h004CCCD);
      settle_en(1'b0);
      rd("enable config", 8'h02, 1, 16'h0017);
      $display("test reset done");
   endtask
   task automatic t_gate();
      logic [19:0] g [9] = '{20'h00006, 20'h00000, 20'h1800C, 20'h1880E,
         20'h1480C, 20'h14806, 20'h1E804, 20'h1E80E, 20'h10006};
      foreach (g[i]) begin
         wr(8'h02, {8'h00, g[i][19:12]}, 1);
         wr(8'h01, {8'h00, g[i][11:4]}, 1);
         on_pin_i = g[i][3];
         power_ok_i = g[i][2];
         settle_en(g[i][1]);
         rd("config", 8'h02, 1, {11'h000, g[i][16:13], 1'b1});
      end
      $display("test gating done");
   endtask
   task automatic t_margin();
      logic [10:0] m [6] = '{11'h060, 11'h0A2, 11'h0C3, 11'h124, 11'h145,
         11'h000};
      wr(8'h25, 16'h0500, 2);
      wr(8'h26, 16'h0480, 2);
      foreach (m[i]) begin
         wr(8'h01, {8'h00, m[i][10:3]}, 1);
         chk("margin", 28'(margin_o), 28'(m[i][2:1]));
         if (m[i][2:1] != 2'h0)
            chk("margin act", 28'(margin_act_o), 28'(m[i][0]));
         chk("margin ref", ref_code_o, m[i][2] ? 28'h0050000 :
            m[i][1] ? 28'h0048000 : 28'h004CCCD);
      end
      wr(8'h25, 16'hFFFF, 2);
      rd("margin high", 8'h25, 2, 16'h0500);
      rd("comms", 8'h7E, 1, 16'h0040);
      wr(8'h03, 16'h0000, 0);
      chk("alert", 28'(alert_oe_b), 28'h0000001);
      $display("test margin done");
   endtask
   task automatic t_trim();
      wr(8'h22, 16'h0100, 2);
      chk("trim ref", ref_code_o, 28'h005CCCD);
      rd("trim", 8'h22, 2, 16'h0100);
      wr(8'h22, 16'hFF00, 2);
      chk("trim ref", ref_code_o, 28'h003CCCD);
      wr(8'h22, 16'h0200, 2);
      chk("trim ref", ref_code_o, 28'h004CCCD);
      chk("alert", 28'(alert_oe_b), 28'h0000000);
      rd("summary", 8'h78, 1, 16'h0002);
      rd("comms", 8'h7E, 1, 16'h0040);
      wr(8'h03, 16'h0000, 0);
      chk("alert", 28'(alert_oe_b), 28'h0000001);
      wr(8'h22, 16'h4000, 2);
      rd("comms", 8'h7E, 1, 16'h0040);
      wr(8'h03, 16'h0000, 0);
      rd("ratio", 8'h29, 2, 16'hB900);
      wr(8'h29, 16'hBA00, 2);
      rd("ratio", 8'h29, 2, 16'hBA00);
      wr(8'h22, 16'h0080, 2);
      chk("ratio ref", ref_code_o, 28'h005CCCD);
      $display("test trim done");
   endtask
   task automatic t_rise();
      logic [9:0] r [8] = '{10'h00A, 10'h00E, 10'h013, 10'h01D, 10'h02B,
         10'h043, 10'h060, 10'h090};
      for (int i = 7; i >= 0; i--) begin
         wr(8'h61, {6'h38, r[i]}, 2);
         chk("rise code", 28'(rise_sel_o), 28'(i));
      end
      rd("rise word", 8'h61, 2, 16'hE00A);
      $display("test rise done");
   endtask
   task automatic t_status();
      rd("oc warn", 8'h4A, 2, 16'hF832);
      wr(8'h4A, 16'hF805, 2);
      rd("oc warn", 8'h4A, 2, 16'hF832);
      ot_fault_i = 1'b1;
      ot_warn_i = 1'b1;
      repeat (8) @(negedge clk_i);
      ot_fault_i = 1'b0;
      ot_warn_i = 1'b0;
      rd("thermal", 8'h7D, 1, 16'h00C0);
      rd("summary", 8'h78, 1, 16'h0004);
      wr(8'h03, 16'h0000, 0);
      rd("thermal", 8'h7D, 1, 16'h0000);
      $display("test status done");
   endtask
   task automatic t_pec();
      u_host.lo_ext = 24;
      u_host.write_cmd(8'h01, 16'h0080, 1, 1'b1);
      u_host.write_cmd(8'h55, 16'h0000, 0, 1'b0);
      rd("operation", 8'h01, 1, 16'h0000);
      rd("comms", 8'h7E, 1, 16'h00A0);
      wr(8'h03, 16'h0000, 0);
      wr(8'h11, 16'h0000, 0);
      chk("store pulses", 28'(store_cnt), 28'h0000001);
      u_host.lo_ext = 0;
      $display("test checking byte done");
   endtask
   initial begin
      repeat (4) @(negedge clk_i);
      rst_b_i = 1'b1;
      repeat (2) @(negedge clk_i);
      t_reset();
      t_gate();
      t_margin();
      t_trim();
      t_rise();
      t_status();
      t_pec();
      test_done();
   end
endmodule // ococs_core_test
